/* File: cld_busy_timer.sv */
`timescale 1ns/1ns
module cld_busy_timer import cld_pkg::*; #(
  parameter int W = TIMER_W
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic running
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
  } cld_tmr_t;

  cld_tmr_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.cnt = loadVal;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
    st_d.run = (st_d.cnt != '0);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign running = st_q.run;
endmodule

/* File: cld_decoder_monitor.sv */
`timescale 1ns/1ns
module cld_decoder_monitor import cld_pkg::*; #(
  parameter int CLEAR_WAIT = CLEAR_CYCLES,
  parameter int SHORT_WAIT = SHORT_CYCLES,
  parameter int RAM_WAIT = RAM_CYCLES,
  parameter int BLINK_HALF = BLINK_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic busEnable,
  input wire logic registerSelect,
  input wire logic readNotWrite,
  input wire logic [7:0] busDataIn,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe,
  input wire cld_mode_t modeFlags,
  input wire logic [6:0] addressCounter,
  input wire logic glyphSelect,
  input wire logic [6:0] shiftOffset,
  input wire logic busyFlag,
  input wire logic cursorDots
);
  // Mirror of the two-flop pin synchroniser, so decode lines up with the design's take edge
  logic [2:0] eS;
  logic [1:0] rsS;
  logic [1:0] rwS;
  logic [7:0] dA;
  logic [7:0] dB;
  logic [17:0] busyLen;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eS <= 3'h0;
      rsS <= 2'h0;
      rwS <= 2'h0;
      dA <= 8'h00;
      dB <= 8'h00;
      busyLen <= 18'h0;
    end else if (clkEn) begin
      eS <= {eS[1:0], busEnable};
      rsS <= {rsS[0], registerSelect};
      rwS <= {rwS[0], readNotWrite};
      dA <= busDataIn;
      dB <= dA;
      busyLen <= busyFlag ? busyLen + 18'h1 : 18'h0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_take;
    clkEn && eS[2] && !eS[1] && !busyFlag && modeFlags.busWidth8;
  endsequence
  sequence s_instr;
    s_take ##0 (!rsS[1] && !rwS[1]);
  endsequence
  sequence s_wrdata;
    s_take ##0 (rsS[1] && !rwS[1]);
  endsequence
  a_clear_homes_all: assert property (s_instr ##0 (dB == 8'h01) |-> ##[1:2]
    (addressCounter == 7'h00 && modeFlags.entryInc && shiftOffset == 7'h00))
    else $error("clear left counter, shift or direction wrong");
  a_home_zeroes: assert property (s_instr ##0 (dB[7:1] == 7'h01) |-> ##[1:2]
    (addressCounter == 7'h00 && shiftOffset == 7'h00)) else $error("return home wrong");
  a_write_steps: assert property (s_wrdata ##0 (!modeFlags.twoLine && !glyphSelect
    && addressCounter != 7'h4f && addressCounter != 7'h00) |-> ##1 (addressCounter ==
    ($past(modeFlags.entryInc) ? $past(addressCounter) + 7'h1 : $past(addressCounter) - 7'h1)))
    else $error("data write stepped counter wrongly");
  a_cursor_moves: assert property (s_instr ##0 (dB[7:3] == 5'h02 && !glyphSelect
    && !modeFlags.twoLine && addressCounter != 7'h4f && addressCounter != 7'h00) |-> ##1
    (addressCounter == ($past(dB[2]) ? $past(addressCounter) + 7'h1
    : $past(addressCounter) - 7'h1))) else $error("cursor shift stepped counter wrongly");
  a_disp_shift_keep: assert property (s_instr ##0 (dB[7:3] == 5'h03) |-> ##1
    ($stable(addressCounter) && shiftOffset != $past(shiftOffset)))
    else $error("display shift moved counter or kept offset");
  a_fn_set_bits: assert property (s_instr ##0 (dB[7:5] == 3'h1) |-> ##1
    (modeFlags.busWidth8 == $past(dB[4]) && modeFlags.twoLine == $past(dB[3])
    && modeFlags.bigFont == $past(dB[2]))) else $error("function set bits not taken");
  a_onoff_bits: assert property (s_instr ##0 (dB[7:3] == 5'h01) |-> ##1
    (modeFlags.displayOn == $past(dB[2]) && modeFlags.cursorOn == $past(dB[1])
    && modeFlags.blinkOn == $past(dB[0]) && $stable(modeFlags.entryInc)))
    else $error("display control bits not taken");
  a_glyph_addr: assert property (s_instr ##0 (dB[7:6] == 2'h1) |-> ##1
    (glyphSelect && addressCounter == {1'b0, $past(dB[5:0])})) else $error("glyph address wrong");
  a_disp_addr: assert property (s_instr ##0 dB[7] |-> ##1
    (!glyphSelect && addressCounter == $past(dB[6:0]))) else $error("display address wrong");
  a_status_read: assert property ($rose(busDataOe) && modeFlags.busWidth8
    && !registerSelect |-> ##1 (busDataOut[6:0] == $past(addressCounter)))
    else $error("status read counter wrong");
  a_busy_length: assert property ($fell(busyFlag) |-> (busyLen == SHORT_WAIT + 1
    || busyLen == RAM_WAIT + 1 || busyLen == CLEAR_WAIT + 1)) else $error("busy length wrong");
  a_blink_off: assert property (!modeFlags.blinkOn && $past(!modeFlags.blinkOn)
    |-> !cursorDots) else $error("cursor dots without blink");
endmodule

bind cld_instr_decoder cld_decoder_monitor #(.CLEAR_WAIT(CLEAR_WAIT), .SHORT_WAIT(SHORT_WAIT),
  .RAM_WAIT(RAM_WAIT), .BLINK_HALF(BLINK_HALF)) u_mon (.core_clk(core_clk), .arst_n(arst_n),
  .clkEn(clkEn), .busEnable(busEnable), .registerSelect(registerSelect),
  .readNotWrite(readNotWrite), .busDataIn(busDataIn), .busDataOut(busDataOut),
  .busDataOe(busDataOe), .modeFlags(modeFlags), .addressCounter(addressCounter),
  .glyphSelect(glyphSelect), .shiftOffset(shiftOffset), .busyFlag(busyFlag),
  .cursorDots(cursorDots));

/* File: cld_host_model.sv */
`timescale 1ns/1ns
module cld_host_model import cld_pkg::*; (
  input wire logic core_clk,
  output logic busEnable,
  output logic registerSelect,
  output logic readNotWrite,
  output logic [7:0] busDataIn,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe
);
  logic nibbleMode = 1'b0;
  int stalls = 0;
  initial begin
    busEnable = 1'b0;
    registerSelect = 1'b0;
    readNotWrite = 1'b0;
    busDataIn = 8'h00;
  end
  // Qualifiers stay put well past the fall so the synchronised copy is stable
  task automatic strobe(input logic rs, input logic rw, input logic [7:0] v, output logic [7:0] r);
    @(posedge core_clk);
    #2;
    registerSelect = rs;
    readNotWrite = rw;
    busDataIn = rw ? ~busDataIn : v;
    busEnable = 1'b1;
    repeat (8) @(posedge core_clk);
    #2;
    // Data counts while the device drives the bus on a read, or leaves it undriven on a write
    r = (busDataOe === rw) ? busDataOut : 8'hxx;
    busEnable = 1'b0;
    repeat (5) @(posedge core_clk);
    #2;
    busDataIn = ~busDataIn;
  endtask
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] v, output logic [7:0] r);
    logic [7:0] hi;
    logic [7:0] lo;
    if (nibbleMode) begin
      strobe(rs, rw, {v[7:4], 4'h0}, hi);
      strobe(rs, rw, {v[3:0], 4'h0}, lo);
      r = {hi[7:4], lo[7:4]};
    end else begin
      strobe(rs, rw, v, r);
    end
  endtask
  task automatic waitIdle();
    logic [7:0] st;
    st = 8'h80;
    for (int i = 0; i < 40 && st[7] !== 1'b0; i++) xfer(1'b0, 1'b1, 8'h00, st);
    if (st[7] !== 1'b0) stalls++;
  endtask
  task automatic cmd(input logic [7:0] v);
    logic [7:0] r;
    xfer(1'b0, 1'b0, v, r);
    waitIdle();
  endtask
  task automatic wr(input logic [7:0] v);
    logic [7:0] r;
    xfer(1'b1, 1'b0, v, r);
    waitIdle();
  endtask
  task automatic rd(output logic [7:0] r);
    xfer(1'b1, 1'b1, 8'h00, r);
    waitIdle();
  endtask
endmodule

/* File: cld_instr_decoder.sv */
`timescale 1ns/1ns
module cld_instr_decoder import cld_pkg::*; #(
  parameter int CLEAR_WAIT = CLEAR_CYCLES,
  parameter int SHORT_WAIT = SHORT_CYCLES,
  parameter int RAM_WAIT = RAM_CYCLES,
  parameter int BLINK_HALF = BLINK_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic busEnable,
  input wire logic registerSelect,
  input wire logic readNotWrite,
  input wire logic [7:0] busDataIn,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  output cld_mode_t modeFlags,
  output logic [6:0] addressCounter,
  output logic glyphSelect,
  output logic [6:0] shiftOffset,
  output logic busyFlag,
  output logic cursorDots
);

  localparam cld_state_t STATE_RESET = '{
    syncA: '0, syncB: '0, eLast: 1'b0, phase: ST_IDLE, mode: MODE_RESET,
    ac: AC_RESET, glyphSel: 1'b0, shiftOff: 7'h00, readLatch: 8'h00,
    hiNib: 4'h0, nibPhase: 1'b0, clrAddr: 7'h00, dOut: 8'h00, dOe: 1'b0,
    busy: 1'b0, blinkCnt: '0, blinkPh: 1'b0, cursorDots: 1'b0};

  cld_state_t st_q, st_d;

  logic tmrLoad;
  logic [TIMER_W-1:0] tmrVal;
  logic tmrRun;
  logic dispWe;
  logic [6:0] dispWaddr;
  logic [7:0] dispWdata;
  logic glyphWe;
  logic [7:0] dispRdata;
  logic [7:0] glyphRdata;

  // Counter step with wrap inside the active address ranges
  function automatic logic [6:0] stepAc(input logic [6:0] a, input logic up,
                                        input logic glyph, input logic two);
    logic [6:0] r;
    r = a;
    if (glyph) begin
      r = up ? {1'b0, 6'(a[5:0] + 6'h01)} : {1'b0, 6'(a[5:0] - 6'h01)};
    end else if (two) begin
      if (up) begin
        r = (a == LINE1_END) ? LINE2_START :
            (a == LINE2_END) ? AC_RESET : 7'(a + 7'h01);
      end else begin
        r = (a == AC_RESET) ? LINE2_END :
            (a == LINE2_START) ? LINE1_END : 7'(a - 7'h01);
      end
    end else begin
      if (up) begin
        r = (a >= ONE_LINE_END) ? AC_RESET : 7'(a + 7'h01);
      end else begin
        r = (a == AC_RESET) ? ONE_LINE_END : 7'(a - 7'h01);
      end
    end
    return r;
  endfunction

  // One offset serves every line, so all lines rotate together in their range
  function automatic logic [6:0] stepShift(input logic [6:0] off, input logic left,
                                           input logic two);
    logic [6:0] last;
    logic [6:0] r;
    last = two ? SHIFT_LAST_TWO : SHIFT_LAST_ONE;
    if (left) begin
      r = (off >= last) ? 7'h00 : 7'(off + 7'h01);
    end else begin
      r = (off == 7'h00) ? last : 7'(off - 7'h01);
    end
    return r;
  endfunction

  always_comb begin
    logic e;
    logic rs;
    logic rw;
    logic [7:0] din;
    logic fall;
    logic done;
    logic [7:0] byteIn;
    logic [7:0] rdByte;
    e = 1'b0;
    rs = 1'b0;
    rw = 1'b0;
    din = 8'h00;
    fall = 1'b0;
    done = 1'b0;
    byteIn = 8'h00;
    rdByte = 8'h00;
    st_d = st_q;
    tmrLoad = 1'b0;
    tmrVal = '0;
    dispWe = 1'b0;
    dispWaddr = st_q.ac;
    dispWdata = busDataIn;
    glyphWe = 1'b0;

    // Pins cross into the core clock through two flops
    st_d.syncA = {busEnable, registerSelect, readNotWrite, busDataIn};
    st_d.syncB = st_q.syncA;
    e = st_q.syncB[10];
    rs = st_q.syncB[9];
    rw = st_q.syncB[8];
    din = st_q.syncB[7:0];
    st_d.eLast = e;
    fall = st_q.eLast && !e;

    // Transfers complete on the falling strobe; four-bit mode needs two
    if (fall) begin
      if (st_q.mode.busWidth8) begin
        done = 1'b1;
        byteIn = din;
      end else if (!st_q.nibPhase) begin
        st_d.hiNib = din[7:4];
        st_d.nibPhase = 1'b1;
      end else begin
        done = 1'b1;
        byteIn = {st_q.hiNib, din[7:4]};
        st_d.nibPhase = 1'b0;
      end
    end

    // Read drive: busy and counter for status, prefetched byte for data
    rdByte = rs ? st_q.readLatch : {st_q.busy, st_q.ac};
    st_d.dOe = e && rw;
    if (st_q.mode.busWidth8 || !st_q.nibPhase) begin
      st_d.dOut = rdByte;
    end else begin
      st_d.dOut = {rdByte[3:0], 4'h0};
    end

    // A busy device ignores writes and data reads; status reads always work
    if (done && !st_q.busy && !(rw && !rs)) begin
      if (!rs && !rw) begin
        casez (byteIn)
          8'b1???????: begin
            st_d.ac = byteIn[6:0];
            st_d.glyphSel = 1'b0;
            st_d.phase = ST_FETCH;
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(SHORT_WAIT);
          end
          8'b01??????: begin
            st_d.ac = {1'b0, byteIn[5:0]};
            st_d.glyphSel = 1'b1;
            st_d.phase = ST_FETCH;
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(SHORT_WAIT);
          end
          8'b001?????: begin
            st_d.mode.busWidth8 = byteIn[FN_WIDTH_BIT];
            st_d.mode.twoLine = byteIn[FN_LINES_BIT];
            st_d.mode.bigFont = byteIn[FN_FONT_BIT];
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(SHORT_WAIT);
          end
          8'b0001????: begin
            if (byteIn[SHIFT_DISP_BIT]) begin
              st_d.shiftOff = stepShift(st_q.shiftOff, !byteIn[SHIFT_RIGHT_BIT],
                                        st_q.mode.twoLine);
            end else begin
              st_d.ac = stepAc(st_q.ac, byteIn[SHIFT_RIGHT_BIT], st_q.glyphSel,
                               st_q.mode.twoLine);
              st_d.phase = ST_FETCH;
            end
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(SHORT_WAIT);
          end
          8'b00001???: begin
            st_d.mode.displayOn = byteIn[DISP_ON_BIT];
            st_d.mode.cursorOn = byteIn[CURSOR_ON_BIT];
            st_d.mode.blinkOn = byteIn[BLINK_ON_BIT];
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(SHORT_WAIT);
          end
          8'b000001??: begin
            st_d.mode.entryInc = byteIn[ENTRY_INC_BIT];
            st_d.mode.entryDisplayShift = byteIn[ENTRY_SHIFT_BIT];
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(SHORT_WAIT);
          end
          8'b0000001?: begin
            st_d.ac = AC_RESET;
            st_d.shiftOff = 7'h00;
            st_d.glyphSel = 1'b0;
            st_d.phase = ST_FETCH;
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(CLEAR_WAIT);
          end
          8'b00000001: begin
            st_d.ac = AC_RESET;
            st_d.glyphSel = 1'b0;
            st_d.shiftOff = 7'h00;
            st_d.mode.entryInc = 1'b1;
            st_d.clrAddr = 7'h00;
            st_d.phase = ST_CLEAR;
            tmrLoad = 1'b1;
            tmrVal = TIMER_W'(CLEAR_WAIT);
          end
          default: begin
          end
        endcase
      end else if (rs && !rw) begin
        dispWe = !st_q.glyphSel;
        glyphWe = st_q.glyphSel;
        dispWdata = byteIn;
        st_d.ac = stepAc(st_q.ac, st_q.mode.entryInc, st_q.glyphSel,
                         st_q.mode.twoLine);
        if (!st_q.glyphSel && st_q.mode.entryDisplayShift) begin
          st_d.shiftOff = stepShift(st_q.shiftOff, st_q.mode.entryInc,
                                    st_q.mode.twoLine);
        end
        // No prefetch here, so a following read sees the older byte
        tmrLoad = 1'b1;
        tmrVal = TIMER_W'(RAM_WAIT);
      end else begin
        st_d.ac = stepAc(st_q.ac, st_q.mode.entryInc, st_q.glyphSel,
                         st_q.mode.twoLine);
        st_d.phase = ST_FETCH;
        tmrLoad = 1'b1;
        tmrVal = TIMER_W'(RAM_WAIT);
      end
    end

    case (st_q.phase)
      ST_IDLE: begin
      end
      ST_CLEAR: begin
        dispWe = 1'b1;
        dispWaddr = st_q.clrAddr;
        dispWdata = SPACE_CODE;
        st_d.clrAddr = 7'(st_q.clrAddr + 7'h01);
        if (st_q.clrAddr == CLEAR_LAST) begin
          st_d.phase = ST_IDLE;
        end
      end
      ST_FETCH: begin
        st_d.phase = ST_LATCH;
      end
      ST_LATCH: begin
        st_d.readLatch = st_q.glyphSel ? glyphRdata : dispRdata;
        st_d.phase = ST_IDLE;
      end
      default: begin
        st_d.phase = ST_IDLE;
      end
    endcase

    st_d.busy = (st_d.phase != ST_IDLE) || tmrLoad || tmrRun;

    // Blink runs only while enabled so the cell starts on the character
    if (st_q.mode.blinkOn) begin
      if (st_q.blinkCnt >= BLINK_W'(BLINK_HALF - 1)) begin
        st_d.blinkCnt = '0;
        st_d.blinkPh = !st_q.blinkPh;
      end else begin
        st_d.blinkCnt = BLINK_W'(st_q.blinkCnt + 1'b1);
      end
    end else begin
      st_d.blinkCnt = '0;
      st_d.blinkPh = 1'b0;
    end
    st_d.cursorDots = st_q.mode.displayOn && st_q.mode.blinkOn && st_q.blinkPh;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= STATE_RESET;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  cld_busy_timer #(
    .W(TIMER_W)
  ) u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .load(tmrLoad),
    .loadVal(tmrVal),
    .running(tmrRun)
  );

  cld_ram #(
    .AW(DISP_AW),
    .DW(8)
  ) u_disp_ram (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .we(dispWe),
    .waddr(dispWaddr),
    .wdata(dispWdata),
    .raddr(st_q.ac),
    .rdata(dispRdata)
  );

  cld_ram #(
    .AW(GLYPH_AW),
    .DW(8)
  ) u_glyph_ram (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .we(glyphWe),
    .waddr(st_q.ac[5:0]),
    .wdata(dispWdata),
    .raddr(st_q.ac[5:0]),
    .rdata(glyphRdata)
  );

  assign busDataOut = st_q.dOut;
  assign busDataOe = st_q.dOe;
  assign modeFlags = st_q.mode;
  assign addressCounter = st_q.ac;
  assign glyphSelect = st_q.glyphSel;
  assign shiftOffset = st_q.shiftOff;
  assign busyFlag = st_q.busy;
  assign cursorDots = st_q.cursorDots;
endmodule

/* File: cld_pkg.sv */
package cld_pkg;

  // Core clock and time bases
  localparam int CLK_FREQ_KHZ = 50000;
  localparam real CLEAR_TIME_MS = 1.53;
  localparam real SHORT_TIME_US = 39.0;
  localparam real RAM_TIME_US = 43.0;
  localparam real BLINK_TIME_MS = 250.0;
  localparam int CLEAR_CYCLES = int'(CLEAR_TIME_MS * CLK_FREQ_KHZ);
  localparam int SHORT_CYCLES = int'(SHORT_TIME_US * CLK_FREQ_KHZ / 1000.0);
  localparam int RAM_CYCLES = int'(RAM_TIME_US * CLK_FREQ_KHZ / 1000.0);
  localparam int BLINK_CYCLES = int'(BLINK_TIME_MS * CLK_FREQ_KHZ);
  localparam int TIMER_W = 17;
  localparam int BLINK_W = 24;

  // Address map of the display and glyph memories
  localparam int DISP_AW = 7;
  localparam int GLYPH_AW = 6;
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam logic [6:0] LINE1_END = 7'h27;
  localparam logic [6:0] LINE2_START = 7'h40;
  localparam logic [6:0] LINE2_END = 7'h67;
  localparam logic [6:0] ONE_LINE_END = 7'h4f;
  localparam logic [6:0] SHIFT_LAST_TWO = 7'h27;
  localparam logic [6:0] SHIFT_LAST_ONE = 7'h4f;
  localparam logic [6:0] CLEAR_LAST = 7'h7f;
  localparam logic [7:0] SPACE_CODE = 8'h20;

  // Field positions inside instruction bytes
  localparam int ENTRY_INC_BIT = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int DISP_ON_BIT = 2;
  localparam int CURSOR_ON_BIT = 1;
  localparam int BLINK_ON_BIT = 0;
  localparam int SHIFT_DISP_BIT = 3;
  localparam int SHIFT_RIGHT_BIT = 2;
  localparam int FN_WIDTH_BIT = 4;
  localparam int FN_LINES_BIT = 3;
  localparam int FN_FONT_BIT = 2;

  typedef struct packed {
    logic displayOn;
    logic cursorOn;
    logic blinkOn;
    logic twoLine;
    logic bigFont;
    logic busWidth8;
    logic entryInc;
    logic entryDisplayShift;
  } cld_mode_t;

  localparam cld_mode_t MODE_RESET = 8'h06;

  typedef enum logic [2:0] {ST_IDLE, ST_CLEAR, ST_FETCH, ST_LATCH} cld_phase_t;

  typedef struct packed {
    logic [10:0] syncA;
    logic [10:0] syncB;
    logic eLast;
    cld_phase_t phase;
    cld_mode_t mode;
    logic [6:0] ac;
    logic glyphSel;
    logic [6:0] shiftOff;
    logic [7:0] readLatch;
    logic [3:0] hiNib;
    logic nibPhase;
    logic [6:0] clrAddr;
    logic [7:0] dOut;
    logic dOe;
    logic busy;
    logic [BLINK_W-1:0] blinkCnt;
    logic blinkPh;
    logic cursorDots;
  } cld_state_t;

endpackage

/* File: cld_ram.sv */
`timescale 1ns/1ns
module cld_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk) begin
    if (clkEn && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read: the caller waits one cycle after moving the address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (clkEn) begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* File: tb_cld_instr_decoder.sv */
`timescale 1ns/1ns
module tb_cld_instr_decoder;
  import cld_pkg::*;
  localparam int CLR_N = 200;
  localparam int SHT_N = 10;
  localparam int RAM_N = 12;
  logic core_clk, arst_n, clkEn, busEnable, registerSelect, readNotWrite, busDataOe;
  logic glyphSelect, busyFlag, cursorDots;
  logic [7:0] busDataIn, busDataOut, r;
  logic [6:0] addressCounter, shiftOffset;
  cld_mode_t modeFlags;
  logic [17:0] busyRun = 18'h0;
  logic [17:0] lastRun = 18'h0;
  int errors = 0;
  int compares = 0;
  int tog;
  cld_instr_decoder #(.CLEAR_WAIT(CLR_N), .SHORT_WAIT(SHT_N), .RAM_WAIT(RAM_N),
    .BLINK_HALF(8)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .busEnable(busEnable), .registerSelect(registerSelect), .readNotWrite(readNotWrite),
    .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
    .modeFlags(modeFlags), .addressCounter(addressCounter), .glyphSelect(glyphSelect),
    .shiftOffset(shiftOffset), .busyFlag(busyFlag), .cursorDots(cursorDots));
  cld_host_model u_host (.core_clk(core_clk), .busEnable(busEnable),
    .registerSelect(registerSelect), .readNotWrite(readNotWrite), .busDataIn(busDataIn),
    .busDataOut(busDataOut), .busDataOe(busDataOe));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (busyFlag === 1'b1) busyRun <= busyRun + 18'h1;
    else begin
      if (busyRun != 18'h0) lastRun <= busyRun;
      busyRun <= 18'h0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(90000 * 20);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    repeat (12) @(posedge core_clk);
    chk(modeFlags, 8'h06, "reset mode");
    chk({glyphSelect, busyFlag, addressCounter, shiftOffset}, 0, "reset state");
    #2 arst_n = 1'b1;
    u_host.cmd(8'h01);
    chk(lastRun, CLR_N + 1, "clear busy");
    chk({addressCounter, modeFlags.entryInc}, 8'h01, "clear home");
    u_host.wr(8'h41);
    chk(lastRun, RAM_N + 1, "write busy");
    u_host.wr(8'h42);
    u_host.wr(8'h43);
    chk(addressCounter, 7'h03, "write step");
    u_host.cmd(8'h80);
    chk(lastRun, SHT_N + 1, "addr busy");
    u_host.rd(r);
    chk(r, 8'h41, "read 0");
    u_host.rd(r);
    u_host.rd(r);
    chk(r, 8'h43, "read 2");
    u_host.rd(r);
    chk(r, 8'h20, "cleared word");
    u_host.cmd(8'h10);
    u_host.cmd(8'h10);
    u_host.cmd(8'h10);
    chk(addressCounter, 7'h01, "cursor left");
    u_host.rd(r);
    chk(r, 8'h42, "shift prefetch");
    u_host.wr(8'h55);
    u_host.rd(r);
    chk(r, 8'h43, "stale after write");
    u_host.cmd(8'h14);
    chk(addressCounter, 7'h05, "cursor right");
    $display("test ram access done");
    u_host.cmd(8'h04);
    u_host.wr(8'h66);
    chk({addressCounter, shiftOffset}, {7'h04, 7'h00}, "decrement");
    u_host.cmd(8'h07);
    u_host.wr(8'h77);
    chk({addressCounter, shiftOffset}, {7'h05, 7'h01}, "shift left on write");
    u_host.cmd(8'h05);
    u_host.wr(8'h78);
    chk({addressCounter, shiftOffset}, {7'h04, 7'h00}, "shift right on write");
    u_host.cmd(8'h18);
    chk({addressCounter, shiftOffset}, {7'h04, 7'h01}, "display left");
    u_host.cmd(8'h1c);
    u_host.cmd(8'h1c);
    chk(shiftOffset, 7'h4f, "one-line rotate");
    u_host.cmd(8'h02);
    chk({addressCounter, shiftOffset, lastRun}, {14'h0, 18'(CLR_N + 1)}, "home");
    u_host.cmd(8'h80);
    u_host.rd(r);
    chk(r, 8'h41, "home keeps ram");
    $display("test shifting done");
    u_host.cmd(8'h3c);
    chk({modeFlags.twoLine, modeFlags.bigFont}, 2'h3, "two-line big font");
    u_host.cmd(8'h30);
    chk({modeFlags.twoLine, modeFlags.bigFont}, 2'h0, "one-line small font");
    u_host.cmd(8'h38);
    u_host.cmd(8'h06);
    u_host.cmd(8'ha7);
    u_host.wr(8'h21);
    chk(addressCounter, 7'h40, "line wrap");
    u_host.cmd(8'h1c);
    chk(shiftOffset, 7'h27, "two-line rotate");
    u_host.cmd(8'h18);
    u_host.cmd(8'h7f);
    chk({glyphSelect, addressCounter}, 8'hbf, "glyph address");
    u_host.wr(8'h1f);
    chk(addressCounter, 7'h00, "glyph step wraps");
    u_host.cmd(8'h7f);
    u_host.rd(r);
    chk(r, 8'h1f, "glyph read");
    $display("test lines and glyphs done");
    u_host.cmd(8'h0f);
    chk(modeFlags[7:5], 3'h7, "all on");
    tog = 0;
    repeat (64) begin
      @(posedge core_clk);
      #2;
      if (cursorDots !== r[0]) tog++;
      r[0] = cursorDots;
    end
    chk(tog >= 6, 1, "blink toggles");
    u_host.cmd(8'h08);
    chk({modeFlags[7:5], cursorDots, modeFlags.entryInc}, 5'h01, "all off");
    $display("test display control done");
    u_host.xfer(1'b0, 1'b0, 8'h28, r);
    u_host.nibbleMode = 1'b1;
    u_host.waitIdle();
    chk(modeFlags.busWidth8, 1'b0, "narrow bus");
    u_host.cmd(8'h92);
    u_host.xfer(1'b0, 1'b1, 8'h00, r);
    chk(r, 8'h12, "nibble status");
    u_host.xfer(1'b0, 1'b0, 8'h38, r);
    u_host.nibbleMode = 1'b0;
    u_host.waitIdle();
    chk(modeFlags.busWidth8, 1'b1, "wide bus");
    $display("test bus width done");
    u_host.xfer(1'b0, 1'b0, 8'h01, r);
    u_host.xfer(1'b0, 1'b1, 8'h00, r);
    chk(r, 8'h80, "busy status");
    u_host.xfer(1'b0, 1'b0, 8'h85, r);
    u_host.waitIdle();
    chk(addressCounter, 7'h00, "refused while busy");
    $display("test busy refusal done");
    u_host.xfer(1'b0, 1'b0, 8'h85, r);
    clkEn = 1'b0;
    repeat (30) @(posedge core_clk);
    #2;
    chk({busyFlag, addressCounter}, 8'h85, "frozen busy");
    clkEn = 1'b1;
    u_host.waitIdle();
    chk(lastRun, SHT_N + 31, "freeze stretches busy");
    @(posedge core_clk);
    #2 arst_n = 1'b0;
    @(posedge core_clk);
    #2 arst_n = 1'b1;
    chk({modeFlags, addressCounter, busyFlag}, {8'h06, 7'h00, 1'b0}, "mid-run reset");
    u_host.cmd(8'h81);
    chk(addressCounter, 7'h01, "address after reset");
    $display("test freeze and reset done");
    chk(u_host.stalls, 0, "poll limit");
    complete_run();
  end
endmodule
